// ==== rtl/gqq_defines.vh ====
// Register offsets, field positions, reset values and codes of the input qualifier
`ifndef GQQ_DEFINES_VH
`define GQQ_DEFINES_VH

// Register byte offsets, one aligned 32-bit word each
`define GQQ_ADDR_W 8
`define GQQ_OFS_A_SPACING 8'h00
`define GQQ_OFS_B_SPACING 8'h04
`define GQQ_OFS_A_SEL_LOW 8'h08
`define GQQ_OFS_A_SEL_HIGH 8'h0C
`define GQQ_OFS_B_SEL_LOW 8'h10
`define GQQ_OFS_B_SEL_HIGH 8'h14
`define GQQ_OFS_A_LEVEL 8'h18
`define GQQ_OFS_B_LEVEL 8'h1C

// Reset values
`define GQQ_RST_SPACING 32'h0000_0000
`define GQQ_RST_SELECT 32'h0000_0000

// Field layout
`define GQQ_SPACING_W 8
`define GQQ_SEL_W 2
`define GQQ_PINS 64
`define GQQ_PINS_PER_PORT 32
`define GQQ_PINS_PER_GROUP 8
`define GQQ_GROUPS 8
`define GQQ_CNT_W 9

// Treatment selector codes
`define GQQ_MODE_SYNC 2'b00
`define GQQ_MODE_QUAL3 2'b01
`define GQQ_MODE_QUAL6 2'b10
`define GQQ_MODE_ASYNC 2'b11

// Sample windows
`define GQQ_WIN_SHORT 3
`define GQQ_WIN_LONG 6

`endif

// ==== rtl/gqq_spacing_div.v ====
// Sample-spacing divider: one-cycle sample enable at the spacing of one pin group
`include "gqq_defines.vh"
`default_nettype none

module gqq_spacing_div (
    input wire sys_clk,
    input wire resetn,
    input wire [`GQQ_SPACING_W-1:0] spacing,
    output reg sample_en_q
);

    reg [`GQQ_CNT_W-1:0] cnt_q;
    reg [`GQQ_CNT_W-1:0] cnt_d;
    reg [`GQQ_CNT_W-1:0] limit;
    reg hit;

    // Zero gives every clock, N gives 2N clocks between samples
    always @* begin
        if (spacing == {`GQQ_SPACING_W{1'b0}}) begin
            limit = {`GQQ_CNT_W{1'b0}};
        end else begin
            limit = {spacing, 1'b0} - 9'h001;
        end
        // A shrinking field must not leave the counter stranded above the limit
        hit = (cnt_q >= limit);
        cnt_d = hit ? {`GQQ_CNT_W{1'b0}} : cnt_q + 9'h001;
    end

    // Counter and enable pulse
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q <= {`GQQ_CNT_W{1'b0}};
            sample_en_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sample_en_q <= hit;
        end
    end

endmodule // gqq_spacing_div

`default_nettype wire

// ==== rtl/gqq_pin_qual.v ====
// Per-pin synchroniser and 3/6-sample qualifier
`include "gqq_defines.vh"
`default_nettype none

module gqq_pin_qual (
    input wire sys_clk,
    input wire resetn,
    input wire pin_raw,
    input wire sample_en,
    input wire [`GQQ_SEL_W-1:0] mode,
    output reg level_q
);

    reg sync1_q;
    reg sync2_q;
    reg [`GQQ_WIN_LONG-1:0] hist_q;
    reg level_d;

    // Two-stage synchroniser; the first stage feeds only the second
    always @(posedge sys_clk) begin
        if (!resetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    // Sample history, newest in bit 0, taken only on the group's spacing pulse
    always @(posedge sys_clk) begin
        if (!resetn) begin
            hist_q <= {`GQQ_WIN_LONG{1'b0}};
        end else if (sample_en) begin
            hist_q <= {hist_q[`GQQ_WIN_LONG-2:0], sync2_q};
        end
    end

    // Level in codes 01 and 10 changes only on a unanimous window, else holds; codes 00 and 11 follow sync2_q
    always @* begin
        level_d = level_q;
        case (mode)
            `GQQ_MODE_QUAL3: begin
                if (&hist_q[`GQQ_WIN_SHORT-1:0]) begin
                    level_d = 1'b1;
                end else if (~|hist_q[`GQQ_WIN_SHORT-1:0]) begin
                    level_d = 1'b0;
                end
            end
            `GQQ_MODE_QUAL6: begin
                if (&hist_q) begin
                    level_d = 1'b1;
                end else if (~|hist_q) begin
                    level_d = 1'b0;
                end
            end
            default: begin
                // Sync only; async code on a GPIO input lands here as well
                level_d = sync2_q;
            end
        endcase
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_d;
        end
    end

endmodule // gqq_pin_qual

`default_nettype wire

// ==== rtl/gqq_input_qualifier.v ====
// Input qualifier top: registers, spacing dividers and 64 pin qualifiers
//
// Function
// - Port B spacing register has four byte fields for pins 32-39, 40-47, 48-55, 56-63.
// - Spacing zero gives one clock; nonzero N gives 2N clocks, 0xFF gives 510.
// - Spacing one gives two clocks, spacing two gives four clocks.
// - Each pin has a 2-bit selector, packed upward from bit 0.
// - Lower port A selector register covers pins 0 to 15.
// - Code 00 synchronises only, for GPIO and peripheral use.
// - Code 01 qualifies over three samples, for GPIO and peripheral use.
// - Code 10 qualifies over six samples, for GPIO and peripheral use.
// - Port A pins take sample spacing from their port A group field.
// - Code 11 passes the raw pin to the peripheral, unsynchronised.
// - Code 11 on a GPIO input behaves as code 00.
// - Spacing and selector writes land only while protected writes are permitted.
// - Upper port A selector register covers pins 16 to 31.
// - Port A spacing register has four byte fields, lowest for pins 0-7.
`include "gqq_defines.vh"
`default_nettype none

module gqq_input_qualifier (
    input wire sys_clk,
    input wire resetn,
    input wire [`GQQ_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire protected_write_permit,
    input wire [`GQQ_PINS-1:0] pin_in,
    input wire [`GQQ_PINS-1:0] periph_assign,
    output reg [`GQQ_PINS-1:0] gpio_level_q,
    output wire [`GQQ_PINS-1:0] periph_level
);

    // Configuration registers
    reg [31:0] port_a_sample_spacing_q;
    reg [31:0] port_b_sample_spacing_q;
    reg [31:0] port_a_qual_select_low_q;
    reg [31:0] port_a_qual_select_high_q;
    reg [31:0] port_b_qual_select_low_q;
    reg [31:0] port_b_qual_select_high_q;

    // Read path
    reg [31:0] rdata_d;

    // Flattened views over all 64 pins
    wire [2*`GQQ_PINS-1:0] sel_all;
    wire [`GQQ_SPACING_W*`GQQ_GROUPS-1:0] spacing_all;
    wire [`GQQ_GROUPS-1:0] group_en;
    wire [`GQQ_PINS-1:0] qual_level;

    // Write qualifiers; a write without permission is dropped silently
    wire wr_ok;
    assign wr_ok = reg_wr && protected_write_permit;

    // Register writes, cleared on reset
    always @(posedge sys_clk) begin
        if (!resetn) begin
            port_a_sample_spacing_q <= `GQQ_RST_SPACING;
            port_b_sample_spacing_q <= `GQQ_RST_SPACING;
            port_a_qual_select_low_q <= `GQQ_RST_SELECT;
            port_a_qual_select_high_q <= `GQQ_RST_SELECT;
            port_b_qual_select_low_q <= `GQQ_RST_SELECT;
            port_b_qual_select_high_q <= `GQQ_RST_SELECT;
        end else if (wr_ok) begin
            if (reg_addr == `GQQ_OFS_A_SPACING) begin
                port_a_sample_spacing_q <= reg_wdata;
            end else if (reg_addr == `GQQ_OFS_B_SPACING) begin
                port_b_sample_spacing_q <= reg_wdata;
            end else if (reg_addr == `GQQ_OFS_A_SEL_LOW) begin
                port_a_qual_select_low_q <= reg_wdata;
            end else if (reg_addr == `GQQ_OFS_A_SEL_HIGH) begin
                port_a_qual_select_high_q <= reg_wdata;
            end else if (reg_addr == `GQQ_OFS_B_SEL_LOW) begin
                port_b_qual_select_low_q <= reg_wdata;
            end else if (reg_addr == `GQQ_OFS_B_SEL_HIGH) begin
                port_b_qual_select_high_q <= reg_wdata;
            end
        end
    end

    // Read decode; level words report the qualified GPIO view
    always @* begin
        if (reg_addr == `GQQ_OFS_A_SPACING) begin
            rdata_d = port_a_sample_spacing_q;
        end else if (reg_addr == `GQQ_OFS_B_SPACING) begin
            rdata_d = port_b_sample_spacing_q;
        end else if (reg_addr == `GQQ_OFS_A_SEL_LOW) begin
            rdata_d = port_a_qual_select_low_q;
        end else if (reg_addr == `GQQ_OFS_A_SEL_HIGH) begin
            rdata_d = port_a_qual_select_high_q;
        end else if (reg_addr == `GQQ_OFS_B_SEL_LOW) begin
            rdata_d = port_b_qual_select_low_q;
        end else if (reg_addr == `GQQ_OFS_B_SEL_HIGH) begin
            rdata_d = port_b_qual_select_high_q;
        end else if (reg_addr == `GQQ_OFS_A_LEVEL) begin
            rdata_d = gpio_level_q[`GQQ_PINS_PER_PORT-1:0];
        end else if (reg_addr == `GQQ_OFS_B_LEVEL) begin
            rdata_d = gpio_level_q[`GQQ_PINS-1:`GQQ_PINS_PER_PORT];
        end else begin
            rdata_d = 32'h0000_0000; // Unmapped reads as zero
        end
    end

    // Read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata_q <= rdata_d;
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    // Selectors packed two bits per pin from bit 0 upward, pin 0 lowest
    assign sel_all = {port_b_qual_select_high_q, port_b_qual_select_low_q,
                      port_a_qual_select_high_q, port_a_qual_select_low_q};

    // Group fields, group 0 = pins 0-7 up to group 7 = pins 56-63
    assign spacing_all = {port_b_sample_spacing_q, port_a_sample_spacing_q};

    // One divider per group of eight pins
    genvar g;
    generate
        for (g = 0; g < `GQQ_GROUPS; g = g + 1) begin : grp
            gqq_spacing_div u_div (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .spacing(spacing_all[g*`GQQ_SPACING_W +: `GQQ_SPACING_W]),
                .sample_en_q(group_en[g])
            );
        end
    endgenerate

    // One qualifier per pin, clocked by its group's sample enable
    genvar p;
    generate
        for (p = 0; p < `GQQ_PINS; p = p + 1) begin : pin
            wire [`GQQ_SEL_W-1:0] mode;
            assign mode = sel_all[p*`GQQ_SEL_W +: `GQQ_SEL_W];

            gqq_pin_qual u_qual (
                .sys_clk(sys_clk),
                .resetn(resetn),
                .pin_raw(pin_in[p]),
                .sample_en(group_en[p/`GQQ_PINS_PER_GROUP]),
                .mode(mode),
                .level_q(qual_level[p])
            );

            // Async code reaches a peripheral unsynchronised; this path is
            // deliberately combinational, so glitches on the pin pass through
            assign periph_level[p] = (periph_assign[p] && (mode == `GQQ_MODE_ASYNC)) ?
                                     pin_in[p] : gpio_level_q[p];
        end
    endgenerate

    // GPIO view is always the synchronised or qualified level
    always @(posedge sys_clk) begin
        if (!resetn) begin
            gpio_level_q <= {`GQQ_PINS{1'b0}};
        end else begin
            gpio_level_q <= qual_level;
        end
    end

endmodule // gqq_input_qualifier

`default_nettype wire

// ==== tb/gqq_pin_source.sv ====
// Off-chip signal source that drives the 64 input pins
`default_nettype none
module gqq_pin_source (
    input wire logic sys_clk,
    input wire logic [63:0] level_set,
    input wire logic [63:0] chatter,
    output var logic [63:0] pin_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_q = 64'h0;
    // Chattering pins flip every clock, like contact bounce
    always @(posedge sys_clk) begin
        pin_q <= (chatter & ~pin_q) | (~chatter & level_set);
    end
endmodule // gqq_pin_source
`default_nettype wire

// ==== tb/gqq_qual_checker.sv ====
// Port checker for the input qualifier
`default_nettype none
module gqq_qual_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic protected_write_permit,
    input wire logic [63:0] pin_in,
    input wire logic [63:0] periph_assign,
    input wire logic [63:0] gpio_level_q,
    input wire logic [63:0] periph_level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // Shadow of the six config words; only permitted writes land
    logic [31:0] sh_q [0:5];
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sh_q <= '{default: 32'h0};
        end else if (reg_wr && protected_write_permit && reg_addr < 8'h18
                     && reg_addr[1:0] == 2'b00) begin
            sh_q[reg_addr[4:2]] <= reg_wdata;
        end
    end
    property p_reset_clear;
        $rose(resetn) |-> gpio_level_q == 64'h0 && reg_rdata_q == 32'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not clear");
    property p_readback;
        // Only aligned word addresses are decoded; others read as zero
        reg_rd && reg_addr < 8'h18 && reg_addr[1:0] == 2'b00
        |=> reg_rdata_q == sh_q[$past(reg_addr[4:2])];
    endproperty
    a_readback: assert property (p_readback) else $error("bad read");
    // Code 00, or 11 on a GPIO pin, is a plain four-clock synchroniser
    property p_sync_pin0;
        (sh_q[2][1:0] == 2'b00 || (sh_q[2][1:0] == 2'b11 && !periph_assign[0])) [*5]
        |-> gpio_level_q[0] == $past(pin_in[0], 4);
    endproperty
    a_sync_pin0: assert property (p_sync_pin0) else $error("sync pin0");
    property p_async_diff;
        ((periph_level ^ gpio_level_q) & (periph_level ^ pin_in)) == 64'h0;
    endproperty
    a_async_diff: assert property (p_async_diff) else $error("periph src");
    property p_gpio_share;
        ((periph_level ^ gpio_level_q) & ~periph_assign) == 64'h0;
    endproperty
    a_gpio_share: assert property (p_gpio_share) else $error("gpio share");
    property p_async_pin0;
        sh_q[2][1:0] == 2'b11 && periph_assign[0] |-> periph_level[0] == pin_in[0];
    endproperty
    a_async_pin0: assert property (p_async_pin0) else $error("async pin0");
    // Toggling every clock at spacing zero never gives a unanimous window
    property p_qual_hold;
        (sh_q[0][7:0] == 8'h00 && (sh_q[2][3:2] == 2'b01 || sh_q[2][3:2] == 2'b10)
        && $changed(pin_in[1])) [*8] |-> $stable(gpio_level_q[1]);
    endproperty
    a_qual_hold: assert property (p_qual_hold) else $error("glitch");
    property p_level_word;
        reg_rd && reg_addr == 8'h18 |=> reg_rdata_q == $past(gpio_level_q[31:0]);
    endproperty
    a_level_word: assert property (p_level_word) else $error("level word");
endmodule // gqq_qual_checker
bind gqq_input_qualifier gqq_qual_checker u_gqq_qual_checker (
    .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .protected_write_permit, .pin_in, .periph_assign, .gpio_level_q, .periph_level
);
`default_nettype wire

// ==== tb/testbench.sv ====
// Bench for the input qualifier: register access and pin treatments
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic permit = 1'b0;
    logic [63:0] periph_assign = 64'h0;
    logic [63:0] level_set = 64'h0;
    logic [63:0] chatter = 64'h0;
    wire [31:0] reg_rdata_q;
    wire [63:0] pin_in;
    wire [63:0] gpio_level_q;
    wire [63:0] periph_level;
    int err_total = 0;
    int tests_run = 0;
    int lat = 0;
    // Spacing A, spacing B, A select low and high, B select low and high
    logic [31:0] cfg [0:5] = '{32'h7F3C_0200, 32'h5A80_FF01, 32'h0001_0007,
        32'hA5A5_A5A5, 32'h0002_0001, 32'h1234_5678};
    gqq_input_qualifier u_gqq_input_qualifier (
        .sys_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .protected_write_permit(permit), .pin_in, .periph_assign, .gpio_level_q,
        .periph_level
    );
    gqq_pin_source u_gqq_pin_source (.sys_clk, .level_set, .chatter, .pin_q(pin_in));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        permit <= p;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata_q", {32'h0, reg_rdata_q}, {32'h0, exp});
    endtask
    // Counts clocks until the pin's level reads high; bounded against a hang
    task automatic span(input int b, input int lo, input int hi);
        while (gpio_level_q[b] !== 1'b1) begin
            @(posedge sys_clk);
            #1;
            lat++;
            if (lat > hi + 2) begin
                err_total++;
                $display("ERROR pin %0d expected high seen timeout", b);
                final_report();
            end
        end
        check("latency in range", 64'(lat >= lo && lat <= hi), 64'h1);
    endtask
    task automatic final_report();
        $display("Checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), 32'h0);
        end
        wr(8'h08, 32'hFFFF_FFFF, 1'b0);
        rd(8'h08, 32'h0);
        // Default treatment: level appears on the fifth edge, not the fourth
        @(posedge sys_clk);
        level_set <= 64'hF0F0_0000_0000_F0F0;
        repeat (4) @(posedge sys_clk);
        #1;
        check("early", gpio_level_q, 64'h0);
        @(posedge sys_clk);
        #1;
        check("sync", gpio_level_q, 64'hF0F0_0000_0000_F0F0);
        @(posedge sys_clk);
        level_set <= 64'h0;
        for (int i = 0; i < 6; i++) begin
            wr(8'(4 * i), cfg[i], 1'b1);
        end
        for (int i = 0; i < 6; i++) begin
            rd(8'(4 * i), cfg[i]);
        end
        rd(8'h40, 32'h0);
        // Peripheral pin 0 in code 11 skips the synchroniser
        @(posedge sys_clk);
        periph_assign <= 64'h1;
        level_set <= 64'h1;
        @(posedge sys_clk);
        #1;
        check("periph_level", periph_level, 64'h1);
        check("gpio_level_q", gpio_level_q, 64'h0);
        @(posedge sys_clk);
        periph_assign <= 64'h0;
        @(posedge sys_clk);
        #1;
        check("gpio fallback", periph_level, 64'h0);
        repeat (2) @(posedge sys_clk);
        #1;
        check("gpio fallback", periph_level, 64'h1);
        // Bounce on qualified pin 1 must not pass
        @(posedge sys_clk);
        level_set <= 64'h0;
        chatter <= 64'h2;
        repeat (40) @(posedge sys_clk);
        #1;
        check("chatter", gpio_level_q, 64'h0);
        @(posedge sys_clk);
        chatter <= 64'h0;
        repeat (10) @(posedge sys_clk);
        level_set <= 64'h0000_0101_0000_0102;
        lat = 0;
        span(1, 8, 8);
        span(32, 10, 11);
        span(8, 14, 17);
        span(40, 2556, 3065);
        // Level words show the qualified GPIO view of each port
        rd(8'h18, 32'h0000_0102);
        rd(8'h1C, 32'h0000_0101);
        final_report();
    end
endmodule // testbench
`default_nettype wire
